/* common/pdrc_map.vh */
// register offsets, field positions and reset values of the power dip restart control
`ifndef PDRC_MAP_VH
`define PDRC_MAP_VH
`define PDRC_OFF_CTRL 12'h000
`define PDRC_OFF_STAT 12'h004
`define PDRC_OFF_IRQ_STAT 12'h008
`define PDRC_OFF_IRQ_MASK 12'h00c
`define PDRC_OFF_FREQ 12'h010
`define PDRC_CTRL_RESET 32'h0000_0000
`define PDRC_IRQ_MASK_RESET 6'h00
// ctrl fields
`define PDRC_CTRL_MODE_LSB 0
`define PDRC_CTRL_START_LSB 4
`define PDRC_CTRL_DECEL_DONE 8
`define PDRC_CTRL_SEARCH_DONE 9
`define PDRC_CTRL_ALARM_CLR 10
// status fields
`define PDRC_STAT_STATE_LSB 0
`define PDRC_STAT_OUT_EN 4
`define PDRC_STAT_ALARM 5
`define PDRC_STAT_UV 6
`define PDRC_STAT_CONT 7
`define PDRC_STAT_SEARCH 8
// interrupt event bits
`define PDRC_EV_UV 0
`define PDRC_EV_CONT 1
`define PDRC_EV_ALARM 2
`define PDRC_EV_RESTORE 3
`define PDRC_EV_RESTART 4
`define PDRC_EV_SEARCH 5
`define PDRC_NEV 6
// states
`define PDRC_ST_RUN 3'h0
`define PDRC_ST_COAST 3'h1
`define PDRC_ST_DECEL 3'h2
`define PDRC_ST_CONT 3'h3
`define PDRC_ST_SEARCH 3'h4
`define PDRC_ST_TRIP 3'h5
`endif

/* rtl/pdrc_top.v */
// power dip restart control: mode sequencing, restart and apb registers
//
// Function
// R1: mode 0 raises the alarm and disables the output at once on undervoltage.
// R2: mode 1 disables the output on undervoltage without the alarm or undervoltage state.
// R3: mode 1 raises the alarm on power restoration and keeps the output disabled.
// R4: mode 2 starts a regenerating deceleration when the bus drops below the running level.
// R5: mode 2 raises the alarm once the deceleration to stop has finished.
// R6: mode 3 enters continuous running control below the running level and waits for power.
// R7: mode 3 stores the output frequency and coasts if undervoltage still occurs.
// R8: without auto search, a run command restarts at the stored frequency on restoration.
// R9: with auto search, a run command searches motor speed and restarts at the found speed.
// R10: auto search is on by terminal command or starting mode setting 1 or 2.
// R11: threshold flags are synchronous and the response is decided in their own cycle.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pdrc_map.vh"

module pdrc_top #(
   parameter FW = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire uv_flag,
   input wire below_cont_level,
   input wire run_cmd,
   input wire auto_search_enable_cmd,
   input wire [FW-1:0] out_freq,
   input wire [FW-1:0] searched_freq,
   output reg out_enable,
   output reg decel_active,
   output reg cont_run_active,
   output reg search_active,
   output reg restart_pulse,
   output reg [FW-1:0] restart_freq,
   output reg uv_alarm,
   output reg irq
);

   reg [31:0] ctrl_reg;
   reg [`PDRC_NEV-1:0] irq_stat_reg;
   reg [`PDRC_NEV-1:0] irq_mask_reg;
   reg [`PDRC_NEV-1:0] ev;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [FW-1:0] saved_freq_reg;
   reg uv_state_reg;
   reg uv_d_reg;
   reg restore_pend_reg;
   reg set_alarm;
   reg do_restart;
   reg do_search;
   reg save_freq;
   reg [31:0] rdata;

   wire [1:0] power_dip_mode_select;
   wire [1:0] starting_mode_setting;
   wire auto_search;
   wire restored;
   wire acc;
   wire wr;

   assign power_dip_mode_select = ctrl_reg[`PDRC_CTRL_MODE_LSB +: 2];
   assign starting_mode_setting = ctrl_reg[`PDRC_CTRL_START_LSB +: 2];
   assign auto_search = auto_search_enable_cmd ||
      (starting_mode_setting == 2'h1) || (starting_mode_setting == 2'h2); // [R10]
   assign restored = uv_d_reg && !uv_flag;
   assign acc = psel && penable;
   assign wr = acc && pwrite;

   function is_addr;
      input [11:0] a;
      input [11:0] off;
      begin
         is_addr = (a == off);
      end
   endfunction

   // apb slave, zero wait state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr[1:0] != 2'h0 ||
            !(is_addr(paddr, `PDRC_OFF_CTRL) || is_addr(paddr, `PDRC_OFF_STAT) ||
              is_addr(paddr, `PDRC_OFF_IRQ_STAT) || is_addr(paddr, `PDRC_OFF_IRQ_MASK) ||
              is_addr(paddr, `PDRC_OFF_FREQ)));
         if (psel && !penable && !pwrite)
            prdata <= rdata;
      end
   end

   always @* begin
      rdata = 32'h0000_0000;
      if (is_addr(paddr, `PDRC_OFF_CTRL))
         rdata = {26'h0, ctrl_reg[5:0]};
      else if (is_addr(paddr, `PDRC_OFF_STAT))
         rdata = {23'h0, search_active, cont_run_active, uv_state_reg, uv_alarm,
            out_enable, 1'b0, state_reg};
      else if (is_addr(paddr, `PDRC_OFF_IRQ_STAT))
         rdata = {26'h0, irq_stat_reg};
      else if (is_addr(paddr, `PDRC_OFF_IRQ_MASK))
         rdata = {26'h0, irq_mask_reg};
      else if (is_addr(paddr, `PDRC_OFF_FREQ))
         rdata = {{(32-FW){1'b0}}, saved_freq_reg};
   end

   // sequencer: flags are taken as synchronous and acted on in their own cycle
   always @* begin
      state_next = state_reg;
      set_alarm = 1'b0;
      do_restart = 1'b0;
      do_search = 1'b0;
      save_freq = 1'b0;
      case (state_reg)
         `PDRC_ST_RUN: begin
            if (uv_flag && power_dip_mode_select == 2'h0) begin
               set_alarm = 1'b1; // [R1] [R11]
               state_next = `PDRC_ST_TRIP;
            end else if (uv_flag && power_dip_mode_select == 2'h1) begin
               state_next = `PDRC_ST_COAST; // [R2] [R11]
            end else if (below_cont_level && power_dip_mode_select == 2'h2) begin
               state_next = `PDRC_ST_DECEL; // [R4] [R11]
            end else if (below_cont_level && power_dip_mode_select == 2'h3) begin
               state_next = `PDRC_ST_CONT; // [R6] [R11]
            end else if (uv_flag) begin
               save_freq = 1'b1;
               state_next = `PDRC_ST_COAST;
            end
         end
         `PDRC_ST_DECEL: begin
            if (ctrl_reg[`PDRC_CTRL_DECEL_DONE] || uv_flag) begin
               set_alarm = 1'b1; // [R5]
               state_next = `PDRC_ST_TRIP;
            end
         end
         `PDRC_ST_CONT: begin
            if (uv_flag) begin
               save_freq = 1'b1; // [R7]
               state_next = `PDRC_ST_COAST;
            end else if (!below_cont_level) begin
               state_next = `PDRC_ST_RUN;
            end
         end
         `PDRC_ST_COAST: begin
            if (restored && power_dip_mode_select == 2'h1) begin
               set_alarm = 1'b1; // [R3]
               state_next = `PDRC_ST_TRIP;
            end else if ((restored || restore_pend_reg) && !uv_flag && run_cmd) begin
               if (auto_search) begin
                  do_search = 1'b1; // [R9]
                  state_next = `PDRC_ST_SEARCH;
               end else begin
                  do_restart = 1'b1; // [R8]
                  state_next = `PDRC_ST_RUN;
               end
            end
         end
         `PDRC_ST_SEARCH: begin
            if (uv_flag) begin
               state_next = `PDRC_ST_COAST;
            end else if (ctrl_reg[`PDRC_CTRL_SEARCH_DONE]) begin
               do_restart = 1'b1; // [R9]
               state_next = `PDRC_ST_RUN;
            end
         end
         `PDRC_ST_TRIP: begin
            if (ctrl_reg[`PDRC_CTRL_ALARM_CLR] && !uv_flag)
               state_next = `PDRC_ST_RUN;
         end
         default: state_next = `PDRC_ST_TRIP;
      endcase
   end

   always @* begin
      ev = {`PDRC_NEV{1'b0}};
      ev[`PDRC_EV_UV] = uv_flag && !uv_d_reg;
      ev[`PDRC_EV_CONT] = (state_next == `PDRC_ST_CONT) && (state_reg != `PDRC_ST_CONT);
      ev[`PDRC_EV_ALARM] = set_alarm;
      ev[`PDRC_EV_RESTORE] = restored;
      ev[`PDRC_EV_RESTART] = do_restart;
      ev[`PDRC_EV_SEARCH] = do_search;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `PDRC_CTRL_RESET;
         irq_mask_reg <= `PDRC_IRQ_MASK_RESET;
         irq_stat_reg <= {`PDRC_NEV{1'b0}};
         irq <= 1'b0;
      end else begin
         // done and clear bits are self clearing strobes
         ctrl_reg[10:8] <= 3'h0;
         if (wr && is_addr(paddr, `PDRC_OFF_CTRL))
            ctrl_reg <= {21'h0, pwdata[10:8], 2'h0, pwdata[5:0]};
         if (wr && is_addr(paddr, `PDRC_OFF_IRQ_MASK))
            irq_mask_reg <= pwdata[`PDRC_NEV-1:0];
         // set wins over write-one-to-clear
         if (wr && is_addr(paddr, `PDRC_OFF_IRQ_STAT))
            irq_stat_reg <= (irq_stat_reg & ~pwdata[`PDRC_NEV-1:0]) | ev;
         else
            irq_stat_reg <= irq_stat_reg | ev;
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= `PDRC_ST_RUN;
         saved_freq_reg <= {FW{1'b0}};
         uv_state_reg <= 1'b0;
         uv_d_reg <= 1'b0;
         restore_pend_reg <= 1'b0;
         out_enable <= 1'b0;
         decel_active <= 1'b0;
         cont_run_active <= 1'b0;
         search_active <= 1'b0;
         restart_pulse <= 1'b0;
         restart_freq <= {FW{1'b0}};
         uv_alarm <= 1'b0;
      end else begin
         state_reg <= state_next;
         uv_d_reg <= uv_flag;
         if (save_freq || (uv_flag && !uv_d_reg && state_reg == `PDRC_ST_RUN))
            saved_freq_reg <= out_freq; // [R7] [R8]
         if (state_next == `PDRC_ST_COAST && restored)
            restore_pend_reg <= 1'b1;
         else if (state_next != `PDRC_ST_COAST || uv_flag)
            restore_pend_reg <= 1'b0;
         // mode 1 coasts without entering the undervoltage state
         uv_state_reg <= uv_flag && power_dip_mode_select != 2'h1; // [R2]
         out_enable <= (state_next == `PDRC_ST_RUN) || (state_next == `PDRC_ST_DECEL) ||
            (state_next == `PDRC_ST_CONT) || (state_next == `PDRC_ST_SEARCH); // [R1] [R7]
         decel_active <= state_next == `PDRC_ST_DECEL; // [R4]
         cont_run_active <= state_next == `PDRC_ST_CONT; // [R6]
         search_active <= state_next == `PDRC_ST_SEARCH; // [R9]
         restart_pulse <= do_restart;
         if (do_restart)
            restart_freq <= (state_reg == `PDRC_ST_SEARCH) ? searched_freq
               : saved_freq_reg; // [R8] [R9]
         if (set_alarm)
            uv_alarm <= 1'b1; // [R1] [R3] [R5]
         else if (state_next == `PDRC_ST_RUN && state_reg == `PDRC_ST_TRIP)
            uv_alarm <= 1'b0;
      end
   end

endmodule

/* test/pdrc_power_stage.sv */
// bus voltage monitor and power stage model
`timescale 1ns/1ps
module pdrc_power_stage #(
   parameter FW = 16
) (
   input wire pclk,
   input wire presetn,
   input wire [1:0] dip,
   input wire [FW-1:0] freq_set,
   input wire [FW-1:0] search_set,
   output reg uv_flag,
   output reg below_cont_level,
   output reg [FW-1:0] out_freq,
   output reg [FW-1:0] searched_freq
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_flag <= 1'h0;
         below_cont_level <= 1'h0;
         out_freq <= {FW{1'h0}};
         searched_freq <= {FW{1'h0}};
      end else begin
         uv_flag <= dip == 2'h2;
         // undervoltage lies below the running level too
         below_cont_level <= dip != 2'h0;
         out_freq <= freq_set;
         searched_freq <= search_set;
      end
   end
endmodule

/* test/pdrc_properties.sv */
// checker of the mode responses at the control block ports
`timescale 1ns/1ps
module pdrc_properties #(
   parameter FW = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire uv_flag,
   input wire below_cont_level,
   input wire run_cmd,
   input wire auto_search_enable_cmd,
   input wire [FW-1:0] out_freq,
   input wire [FW-1:0] searched_freq,
   input wire out_enable,
   input wire decel_active,
   input wire cont_run_active,
   input wire search_active,
   input wire restart_pulse,
   input wire [FW-1:0] restart_freq,
   input wire uv_alarm
);
   reg [1:0] mode_reg;
   reg [FW-1:0] saved_reg;
   wire run_st = out_enable && !decel_active && !cont_run_active && !search_active;
   // shadow of the mode field and of the frequency kept at undervoltage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= 2'h0;
         saved_reg <= {FW{1'h0}};
      end else begin
         if (psel && penable && pwrite && pready && paddr == 12'h000)
            mode_reg <= pwdata[1:0];
         if (mode_reg[1] && (run_st || cont_run_active) && uv_flag)
            saved_reg <= out_freq;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   uv_trip_a:
      assert property (mode_reg == 2'h0 && run_st && uv_flag |=> uv_alarm && !out_enable)
      else $error("no trip");
   coast_quiet_a:
      assert property (mode_reg == 2'h1 && run_st && uv_flag && !uv_alarm |=> !out_enable && !uv_alarm)
      else $error("bad coast");
   restore_alarm_a:
      assert property (mode_reg == 2'h1 && !out_enable && !uv_alarm && $fell(uv_flag)
         |=> uv_alarm && !out_enable) else $error("no alarm on restore");
   decel_start_a:
      assert property (mode_reg == 2'h2 && run_st && below_cont_level && !uv_flag |=> decel_active)
      else $error("no decel");
   decel_alarm_a:
      assert property (mode_reg == 2'h2 && decel_active && psel && penable && pwrite
         && pready && paddr == 12'h000 && pwdata[8] |-> ##2 uv_alarm && !out_enable)
      else $error("no alarm after decel");
   cont_start_a:
      assert property (mode_reg == 2'h3 && run_st && below_cont_level && !uv_flag
         |=> cont_run_active && out_enable) else $error("no cont run");
   cont_coast_a:
      assert property (mode_reg == 2'h3 && cont_run_active && uv_flag
         |=> !out_enable && !cont_run_active) else $error("no coast");
   saved_restart_a:
      assert property (restart_pulse && !$past(search_active)
         |-> restart_freq == saved_reg && $past(run_cmd)) else $error("bad saved restart");
   search_restart_a:
      assert property (restart_pulse && $past(search_active)
         |-> restart_freq == $past(searched_freq)) else $error("bad search restart");
   search_start_a:
      assert property (mode_reg == 2'h3 && !out_enable && !uv_alarm && !search_active && run_cmd
         && auto_search_enable_cmd && $fell(uv_flag) |=> search_active) else $error("no search");
endmodule
bind pdrc_top pdrc_properties #(.FW(FW)) props (.*);

/* test/pdrc_testbench.sv */
// testbench of the power dip restart control
`timescale 1ns/1ps
module testbench;
   localparam FW = 16;
   reg pclk, presetn, psel, penable, pwrite, run_cmd, ast;
   reg [11:0] paddr;
   reg [31:0] pwdata, rnd, cv;
   reg [1:0] dip;
   reg [FW-1:0] fset, sset;
   wire [31:0] prdata;
   wire pready, pslverr, uv, blw, oe, dec, cont, srch, rp, alm, irq;
   wire [FW-1:0] ofr, sfr, rfr;
   integer err_total, checked, cyc, k;
   reg [31:0] q_rd[$], q_rs[$];
   pdrc_top #(.FW(FW)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .uv_flag(uv), .below_cont_level(blw), .run_cmd(run_cmd),
      .auto_search_enable_cmd(ast), .out_freq(ofr), .searched_freq(sfr), .out_enable(oe),
      .decel_active(dec), .cont_run_active(cont), .search_active(srch), .restart_pulse(rp),
      .restart_freq(rfr), .uv_alarm(alm), .irq(irq));
   pdrc_power_stage #(.FW(FW)) ps (.pclk(pclk), .presetn(presetn), .dip(dip),
      .freq_set(fset), .search_set(sset), .uv_flag(uv), .below_cont_level(blw),
      .out_freq(ofr), .searched_freq(sfr));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   task chk(input string n, input [31:0] e, input [31:0] g);
      checked = checked + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("mismatch %0s exp %h got %h", n, e, g);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task apb(input w, input [11:0] a, input [31:0] d, input [31:0] e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         q_rd.push_back(e);
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task tk(input integer n);
      repeat (n) @(posedge pclk);
   endtask
   task dp(input [1:0] v);
      @(posedge pclk);
      dip <= v;
      tk(4);
   endtask
   // read data and restart frequency are matched against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'h1)
         chk("prdata", q_rd.pop_front(), prdata);
      // error response expected for misaligned or unmapped words only
      if (psel && penable && pready === 1'h1)
         chk("pslverr", {31'h0, (paddr[1:0] != 2'h0) || (paddr > 12'h010)}, {31'h0, pslverr});
      if (rp === 1'h1)
         chk("restart_freq", q_rs.pop_front(), {{(32-FW){1'h0}}, rfr});
      cyc = cyc + 1;
      if (cyc == 5000) begin
         err_total = err_total + 1;
         stop_test;
      end
   end
   initial begin
      err_total = 0; checked = 0; cyc = 0; rnd = 32'h0001_2d52;
      presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h0;
      pwdata = 32'h0; run_cmd = 1'h0; ast = 1'h0; dip = 2'h0; fset = 16'h0; sset = 16'h0;
      tk(6);
      presetn <= 1'h1;
      apb(1'h0, 12'h004, 32'h0, 32'h10);
      apb(1'h0, 12'h040, 32'h0, 32'h0);
      apb(1'h0, 12'h006, 32'h0, 32'h0);
      dp(2'h2);
      chk("uv_alarm", 32'h1, alm);
      chk("out_enable", 32'h0, oe);
      chk("irq", 32'h0, irq);
      apb(1'h1, 12'h00c, 32'h3f, 32'h0);
      tk(2);
      chk("irq", 32'h1, irq);
      dp(2'h0);
      apb(1'h1, 12'h000, 32'h400, 32'h0);
      apb(1'h1, 12'h008, 32'h3f, 32'h0);
      tk(2);
      chk("irq", 32'h0, irq);
      chk("out_enable", 32'h1, oe);
      apb(1'h1, 12'h000, 32'h1, 32'h0);
      dp(2'h2);
      chk("out_enable", 32'h0, oe);
      chk("uv_alarm", 32'h0, alm);
      dp(2'h0);
      chk("uv_alarm", 32'h1, alm);
      chk("out_enable", 32'h0, oe);
      apb(1'h1, 12'h000, 32'h402, 32'h0);
      dp(2'h1);
      chk("decel_active", 32'h1, dec);
      apb(1'h1, 12'h000, 32'h102, 32'h0);
      tk(2);
      chk("uv_alarm", 32'h1, alm);
      dp(2'h0);
      apb(1'h1, 12'h000, 32'h403, 32'h0);
      run_cmd <= 1'h1;
      dp(2'h1);
      chk("cont_run", 32'h1, cont);
      chk("out_enable", 32'h1, oe);
      dp(2'h0);
      // plain restart, then search by terminal and by starting modes 1 and 2
      for (k = 0; k < 4; k = k + 1) begin
         rnd = lfsr(rnd);
         fset <= rnd[FW-1:0];
         sset <= ~rnd[FW-1:0];
         ast <= k == 1;
         cv = 32'h3 + ((k > 1) ? (k - 1) * 16 : 0);
         apb(1'h1, 12'h000, cv, 32'h0);
         dp(2'h1);
         dp(2'h2);
         chk("out_enable", 32'h0, oe);
         if (k == 0) begin
            q_rs.push_back({{(32-FW){1'h0}}, fset});
            dp(2'h0);
         end else begin
            dp(2'h0);
            chk("search", 32'h1, srch);
            q_rs.push_back({{(32-FW){1'h0}}, sset});
            apb(1'h1, 12'h000, cv | 32'h200, 32'h0);
            tk(2);
         end
         chk("out_enable", 32'h1, oe);
      end
      tk(4);
      // every noted read and restart must have been seen
      chk("rd_left", 32'h0, q_rd.size());
      chk("restart_left", 32'h0, q_rs.size());
      stop_test;
   end
endmodule
